/* hdl/notch_pkg.sv */
// Package: constants, carriers and helpers of the notch filter bank
package notch_pkg;
	localparam int NUM_NOTCH = 5;
	// Clock and command sample rates
	localparam longint CLK_HZ = 100_000_000;
	localparam int SAMPLE_HZ = 40_000;
	// Frequency limits in Hz
	localparam logic [12:0] FREQ_MIN = 13'h000A;
	localparam logic [12:0] FREQ_MAX = 13'h1194;
	localparam logic [12:0] TUNE_LO  = 13'h0064;
	localparam logic [12:0] TUNE_HI  = 13'h08CA;
	// Hz to Q15 step, round(2*pi*2^23/SAMPLE_HZ)
	localparam logic [15:0] COEF_K = 16'h0526;
	// Observation time and measuring window
	localparam longint TUNE_S  = 10;
	localparam longint WIN_MS  = 1000;
	localparam int TUNE_CYC = int'(TUNE_S * CLK_HZ);
	localparam int WIN_CYC  = int'(WIN_MS * CLK_HZ / 1000);
	// Register byte offsets
	localparam logic [7:0] MODE_OFS     = 8'h00;
	localparam logic [7:0] FREQ_OFS     = 8'h04;
	localparam logic [7:0] SHAPE_OFS    = 8'h08;
	localparam logic [7:0] NOTCH_STRIDE = 8'h08;
	localparam logic [7:0] ROBUST_OFS   = 8'h2C;
	localparam logic [7:0] SHAFT_OFS    = 8'h30;
	localparam logic [7:0] STATUS_OFS   = 8'h34;
	// Tuning mode field values
	localparam logic [1:0] MODE_OFF    = 2'h0;
	localparam logic [1:0] MODE_ADAPT  = 2'h1;
	localparam logic [1:0] MODE_MANUAL = 2'h2;
	// Reset values
	localparam logic [1:0]  MODE_RST   = MODE_OFF;
	localparam logic [12:0] FREQ_RST   = FREQ_MAX;
	localparam logic        ROBUST_RST = 1'b0;
	localparam logic        SHAFT_RST  = 1'b1;
	// Tuning detector and excitation
	localparam logic [15:0] PEAK_MIN   = 16'h0400;
	localparam logic [17:0] EXCITE_AMP = 18'h0_0800;
	localparam logic [15:0] LFSR_SEED  = 16'hACE1;
	localparam logic [15:0] LFSR_TAPS  = 16'hB400;
	// Depth code to notch gain, code 0 deepest
	localparam logic [3:0][15:0] DEPTH_GAIN = {16'h2000, 16'h4000, 16'h6000, 16'h7FFF};
	// Width code to damping, code 0 narrowest
	localparam logic [3:0][15:0] WIDTH_DAMP = {16'h7FFF, 16'h6000, 16'h4000, 16'h2000};

	typedef struct packed {
		logic               valid;
		logic signed [15:0] data;
	} sample_type;

	// Shape field: enable bit 4, width bits 3:2, depth bits 1:0
	typedef struct packed {
		logic       enable;
		logic [1:0] width;
		logic [1:0] depth;
	} shape_type;

	typedef struct packed {
		logic        valid;
		logic        sel;
		logic [12:0] freq;
	} vtd_type;

	typedef enum logic [1:0] {
		T_IDLE    = 2'b00,
		T_OBSERVE = 2'b01,
		T_FINISH  = 2'b10
	} tune_state_type;

	function automatic logic signed [15:0] sat16(input logic signed [17:0] v);
		if (v > 18'sh0_7FFF)
			return 16'sh7FFF;
		if (v < -18'sh0_8000)
			return -16'sh8000;
		return v[15:0];
	endfunction : sat16

	function automatic logic [12:0] clamp_freq(input logic [12:0] f);
		if (f < FREQ_MIN)
			return FREQ_MIN;
		if (f > FREQ_MAX)
			return FREQ_MAX;
		return f;
	endfunction : clamp_freq
endpackage : notch_pkg

/* hdl/notch_section.sv */
// One state-variable notch section with bypass
`timescale 1ns/1ps
`default_nettype none
module notch_section (
	// Clock, reset and freeze
	input  wire logic                  clk,
	input  wire logic                  rst,
	input  wire logic                  ce,
	// Settings
	input  wire logic                  active,
	input  wire logic [12:0]           freq,
	input  wire notch_pkg::shape_type  shape,
	// Samples
	input  wire notch_pkg::sample_type din,
	output notch_pkg::sample_type      dout
);
	typedef struct packed {
		logic signed [17:0]    lp;
		logic signed [17:0]    bp;
		notch_pkg::sample_type out;
	} sect_type;

	sect_type           st_reg;
	sect_type           st_next;
	logic [28:0]        prod;
	logic signed [16:0] f;
	logic signed [16:0] g;
	logic signed [16:0] q;
	logic signed [17:0] x;
	logic signed [17:0] lp_n;
	logic signed [17:0] hp;
	logic signed [17:0] bp_n;
	logic signed [17:0] y;

	function automatic logic signed [17:0] mulq(input logic signed [17:0] a,
		input logic signed [16:0] b);
		logic signed [34:0] p;
		p = a * b;
		return p[32:15];
	endfunction : mulq

	// Coefficients from the frequency and shape codes
	assign prod = freq * notch_pkg::COEF_K;
	assign f = {1'b0, prod[23:8]};
	assign g = {1'b0, notch_pkg::DEPTH_GAIN[shape.depth]};
	assign q = {1'b0, notch_pkg::WIDTH_DAMP[shape.width]};
	assign x = {{2{din.data[15]}}, din.data};

	// Band-pass subtracted from input gives the notch
	always_comb begin
		st_next = st_reg;
		lp_n = st_reg.lp + mulq(st_reg.bp, f);
		hp = x - lp_n - mulq(st_reg.bp, q);
		bp_n = st_reg.bp + mulq(hp, f);
		y = x - mulq(bp_n, g);
		st_next.out.valid = din.valid;
		if (din.valid) begin
			if (active) begin
				st_next.lp = lp_n;
				st_next.bp = bp_n;
				st_next.out.data = notch_pkg::sat16(y);
			end else begin
				// Cleared state avoids a transient when re-enabled
				st_next.lp = '0;
				st_next.bp = '0;
				st_next.out.data = din.data;
			end
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst)
			st_reg <= '0;
		else if (ce)
			st_reg <= st_next;
	end

	assign dout = st_reg.out;
endmodule : notch_section
`default_nettype wire

/* hdl/notch_filter_bank_control.sv */
// Notch filter bank with tuning sequencer and register slave
`timescale 1ns/1ps
`default_nettype none
module notch_filter_bank_control #(
	parameter int unsigned TUNE_CYCLES = notch_pkg::TUNE_CYC,
	parameter int unsigned WIN_CYCLES  = notch_pkg::WIN_CYC
) (
	// Clock, reset and freeze
	input  wire logic                  clk,
	input  wire logic                  rst,
	input  wire logic                  ce,
	// Avalon-MM register slave
	input  wire logic [7:0]            address,
	input  wire logic                  read,
	input  wire logic                  write,
	input  wire logic [31:0]           writedata,
	output logic      [31:0]           readdata,
	output logic                       waitrequest,
	// Command samples
	input  wire notch_pkg::sample_type cmd_in,
	output notch_pkg::sample_type      cmd_out,
	// Vibration feedback and gain level for tuning
	input  wire notch_pkg::sample_type vib_in,
	input  wire logic [1:0]            gain_level,
	// Frequency rewrite from vibration tough drive
	input  wire notch_pkg::vtd_type    vtd_req,
	// Filter status
	output logic [4:0]                 active_mask,
	output logic                       shaft_filter_on,
	output logic                       robust_filter_on,
	output logic                       excite_on
);
	typedef struct packed {
		logic [1:0]                     mode;
		logic [4:0][12:0]               freq;
		notch_pkg::shape_type [4:0]     shape;
		logic                           robust;
		logic                           shaft;
		notch_pkg::tune_state_type      tune;
		logic [29:0]                    tcnt;
		logic [29:0]                    wcnt;
		logic [15:0]                    xings;
		logic [15:0]                    peak;
		logic                           last_neg;
		logic                           found;
		logic [15:0]                    lfsr;
		logic                           wait_q;
		logic [31:0]                    rdata;
		logic [4:0]                     act;
		logic                           shaft_on;
		logic                           robust_on;
		logic                           excite;
		notch_pkg::sample_type          head;
	} ctl_type;

	function automatic ctl_type rst_value();
		ctl_type v;
		v = '0;
		v.mode = notch_pkg::MODE_RST;
		for (int i = 0; i < notch_pkg::NUM_NOTCH; i++)
			v.freq[i] = notch_pkg::FREQ_RST;
		v.robust = notch_pkg::ROBUST_RST;
		v.shaft = notch_pkg::SHAFT_RST;
		v.shaft_on = notch_pkg::SHAFT_RST;
		v.tune = notch_pkg::T_IDLE;
		v.lfsr = notch_pkg::LFSR_SEED;
		v.wait_q = 1'b1;
		return v;
	endfunction : rst_value

	localparam ctl_type CTL_RST = rst_value();

	ctl_type                       st_reg;
	ctl_type                       n;
	logic [15:0]                   abs_vib;
	logic [12:0]                   est;
	logic signed [17:0]            kick;
	notch_pkg::sample_type [5:0]   chain;

	// Register read decode
	function automatic logic [31:0] reg_word(input logic [7:0] a, input ctl_type s);
		logic [31:0] w;
		w = '0;
		if (a == notch_pkg::MODE_OFS)
			w[1:0] = s.mode;
		if (a == notch_pkg::ROBUST_OFS)
			w[0] = s.robust;
		if (a == notch_pkg::SHAFT_OFS)
			w[0] = s.shaft;
		if (a == notch_pkg::STATUS_OFS)
			w[10:0] = {s.excite, s.found, s.robust_on, s.shaft_on, s.act, s.tune};
		for (int i = 0; i < notch_pkg::NUM_NOTCH; i++) begin
			if (a == notch_pkg::FREQ_OFS + 8'(i) * notch_pkg::NOTCH_STRIDE)
				w[12:0] = s.freq[i];
			if (a == notch_pkg::SHAPE_OFS + 8'(i) * notch_pkg::NOTCH_STRIDE)
				w[4:0] = s.shape[i];
		end
		return w;
	endfunction : reg_word

	// Half the zero crossings in a one second window is the frequency
	assign est = st_reg.xings[13:1];
	assign abs_vib = vib_in.data[15] ? 16'(-vib_in.data) : 16'(vib_in.data);
	assign kick = st_reg.lfsr[0] ? notch_pkg::EXCITE_AMP : -notch_pkg::EXCITE_AMP;

	always_comb begin
		n = st_reg;
		// Tuning sequencer
		case (st_reg.tune)
			notch_pkg::T_IDLE: begin
				if (st_reg.mode == notch_pkg::MODE_ADAPT) begin
					n.tune = notch_pkg::T_OBSERVE;
					n.tcnt = '0;
					n.wcnt = '0;
					n.xings = '0;
					n.peak = '0;
					n.found = 1'b0;
				end
			end
			notch_pkg::T_OBSERVE: begin
				n.tcnt = st_reg.tcnt + 30'h0000_0001;
				n.wcnt = st_reg.wcnt + 30'h0000_0001;
				if (vib_in.valid) begin
					n.last_neg = vib_in.data[15];
					if (vib_in.data[15] != st_reg.last_neg)
						n.xings = st_reg.xings + 16'h0001;
					if (abs_vib > st_reg.peak)
						n.peak = abs_vib;
				end
				if (st_reg.wcnt == 30'(WIN_CYCLES - 1)) begin
					n.wcnt = '0;
					n.xings = '0;
					n.peak = '0;
					// Out-of-band resonance is left to manual setting
					if (st_reg.peak >= notch_pkg::PEAK_MIN && st_reg.xings[15:14] == 2'b00 &&
						est >= notch_pkg::TUNE_LO && est <= notch_pkg::TUNE_HI) begin
						n.found = 1'b1;
						n.freq[0] = est;
						n.shape[0].depth = gain_level;
						n.tune = notch_pkg::T_FINISH;
					end
				end
				if (st_reg.tcnt == 30'(TUNE_CYCLES - 1))
					n.tune = notch_pkg::T_FINISH;
				// Software leaving adaptive mode aborts the run
				if (st_reg.mode != notch_pkg::MODE_ADAPT)
					n.tune = notch_pkg::T_IDLE;
			end
			notch_pkg::T_FINISH: begin
				n.mode = notch_pkg::MODE_MANUAL;
				n.tune = notch_pkg::T_IDLE;
			end
			default: begin
				n.tune = notch_pkg::T_IDLE;
			end
		endcase

		// Excitation rides on the command while observing
		n.head.valid = cmd_in.valid;
		n.head.data = cmd_in.data;
		if (cmd_in.valid && st_reg.tune == notch_pkg::T_OBSERVE) begin
			n.lfsr = {st_reg.lfsr[14:0], ^(st_reg.lfsr & notch_pkg::LFSR_TAPS)};
			n.head.data = notch_pkg::sat16({{2{cmd_in.data[15]}}, cmd_in.data} + kick);
		end
		n.excite = n.tune == notch_pkg::T_OBSERVE;

		// Avalon slave: request waits one cycle, answered on the second
		n.wait_q = !((read || write) && st_reg.wait_q);
		if (read && st_reg.wait_q)
			n.rdata = reg_word(address, st_reg);
		if (write && !st_reg.wait_q) begin
			if (address == notch_pkg::MODE_OFS)
				n.mode = writedata[1:0];
			if (address == notch_pkg::ROBUST_OFS)
				n.robust = writedata[0];
			if (address == notch_pkg::SHAFT_OFS)
				n.shaft = writedata[0];
			for (int i = 0; i < notch_pkg::NUM_NOTCH; i++) begin
				if (address == notch_pkg::FREQ_OFS + 8'(i) * notch_pkg::NOTCH_STRIDE)
					n.freq[i] = notch_pkg::clamp_freq(writedata[12:0]);
				if (address == notch_pkg::SHAPE_OFS + 8'(i) * notch_pkg::NOTCH_STRIDE)
					n.shape[i] = writedata[4:0];
			end
		end

		// Drive function reaches notch one or two frequency only
		if (vtd_req.valid)
			n.freq[vtd_req.sel] = notch_pkg::clamp_freq(vtd_req.freq);

		// Enables follow the next settings so status matches registers
		n.act[0] = n.mode == notch_pkg::MODE_MANUAL;
		for (int i = 1; i < 4; i++)
			n.act[i] = n.shape[i].enable;
		n.act[4] = n.shape[4].enable && !n.robust;
		n.shaft_on = n.shaft && !n.shape[3].enable;
		n.robust_on = n.robust;
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst)
			st_reg <= CTL_RST;
		else if (ce)
			st_reg <= n;
	end

	// Cascade of identical sections on one command stream
	assign chain[0] = st_reg.head;
	generate
		for (genvar g = 0; g < notch_pkg::NUM_NOTCH; g++) begin : g_sect
			notch_section u_sect (
				.clk   (clk),
				.rst   (rst),
				.ce    (ce),
				.active(st_reg.act[g]),
				.freq  (st_reg.freq[g]),
				.shape (st_reg.shape[g]),
				.din   (chain[g]),
				.dout  (chain[g + 1])
			);
		end
	endgenerate

	// Outputs straight from state
	assign cmd_out = chain[5];
	assign readdata = st_reg.rdata;
	assign waitrequest = st_reg.wait_q;
	assign active_mask = st_reg.act;
	assign shaft_filter_on = st_reg.shaft_on;
	assign robust_filter_on = st_reg.robust_on;
	assign excite_on = st_reg.excite;

	// Checks
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (rst);

	logic bus_write_now;
	logic freq_ok;
	assign bus_write_now = write && !waitrequest;
	always_comb begin
		freq_ok = 1'b1;
		for (int i = 0; i < notch_pkg::NUM_NOTCH; i++)
			if (st_reg.freq[i] < notch_pkg::FREQ_MIN || st_reg.freq[i] > notch_pkg::FREQ_MAX)
				freq_ok = 1'b0;
	end

	sequence bus_req_s;
		(read || write) && waitrequest && ce;
	endsequence
	sequence finish_s;
		ce && st_reg.tune == notch_pkg::T_FINISH && !bus_write_now;
	endsequence
	sequence handed_s;
		st_reg.mode == notch_pkg::MODE_MANUAL && st_reg.tune == notch_pkg::T_IDLE;
	endsequence
	sequence mode_write_s;
		ce && bus_write_now && address == notch_pkg::MODE_OFS;
	endsequence
	sequence adapt_go_s;
		ce && st_reg.tune == notch_pkg::T_IDLE && st_reg.mode == notch_pkg::MODE_ADAPT;
	endsequence
	// A sample is taken, then five running edges carry it out
	sequence sample_in_s;
		ce && cmd_in.valid;
	endsequence
	sequence run5_s;
		ce [*5];
	endsequence
	// Quiet path: no excitation at the head and every section bypassed
	sequence quiet_in_s;
		ce && cmd_in.valid && st_reg.tune == notch_pkg::T_IDLE && st_reg.act == 5'h00;
	endsequence
	sequence quiet5_s;
		(ce && st_reg.act == 5'h00) [*5];
	endsequence

	// Bus handshake: one wait cycle, one answer cycle, then the write has landed
	chk_bus_answer: assert property (bus_req_s |=> !waitrequest)
		else $error("bus request not answered after one wait cycle");
	chk_wait_pulse: assert property (ce && !waitrequest |=> waitrequest)
		else $error("waitrequest low for more than one cycle");
	chk_mode_write: assert property (mode_write_s |=> st_reg.mode == $past(writedata[1:0]))
		else $error("mode write did not land");
	// Enables against the settings they come from
	chk_shaft_forced_off: assert property (active_mask[3] |-> !shaft_filter_on)
		else $error("shaft filter on while notch four active");
	chk_robust_override: assert property (robust_filter_on |-> !active_mask[4])
		else $error("notch five active under robust filter");
	chk_notch5_select: assert property (
		st_reg.shape[4].enable && !st_reg.robust |-> active_mask[4])
		else $error("notch five not active when selected");
	chk_manual_gate: assert property (
		active_mask[0] == (st_reg.mode == notch_pkg::MODE_MANUAL))
		else $error("notch one enable differs from manual mode");
	chk_notch2_gate: assert property (active_mask[1] == st_reg.shape[1].enable)
		else $error("notch two enable differs from its field");
	chk_notch3_gate: assert property (active_mask[2] == st_reg.shape[2].enable)
		else $error("notch three enable differs from its field");
	// Tuning sequencer
	chk_excite_window: assert property (
		excite_on == (st_reg.tune == notch_pkg::T_OBSERVE))
		else $error("excitation not tied to observation");
	chk_adapt_start: assert property (adapt_go_s |=> excite_on)
		else $error("excitation did not start with adaptive mode");
	chk_tune_bound: assert property (
		st_reg.tune == notch_pkg::T_OBSERVE |-> st_reg.tcnt < 30'(TUNE_CYCLES))
		else $error("observation ran past its limit");
	chk_tune_handoff: assert property (finish_s |=> handed_s)
		else $error("tuning did not hand over to manual");
	chk_tuned_band: assert property (
		$rose(st_reg.found) |-> st_reg.freq[0] >= notch_pkg::TUNE_LO &&
		st_reg.freq[0] <= notch_pkg::TUNE_HI)
		else $error("tuned frequency outside tuning band");
	chk_found_depth: assert property (
		$rose(st_reg.found) |-> st_reg.shape[0].depth == $past(gain_level))
		else $error("tuned depth differs from gain level");
	// Frequencies and the drive function
	chk_freq_range: assert property (freq_ok)
		else $error("notch frequency outside limits");
	chk_vtd_scope: assert property (
		ce && vtd_req.valid && !bus_write_now |=>
		$stable(st_reg.shape[4:1]) && $stable(st_reg.freq[4:2]))
		else $error("drive function touched other settings");
	chk_freq_clamp: assert property (
		ce && vtd_req.valid |=>
		st_reg.freq[$past(vtd_req.sel)] == notch_pkg::clamp_freq($past(vtd_req.freq)))
		else $error("drive rewrite not clamped into place");
	// Samples through the cascade
	chk_cmd_latency: assert property (sample_in_s ##1 run5_s |=> cmd_out.valid)
		else $error("filtered sample late or lost");
	chk_pass_through: assert property (
		quiet_in_s ##1 quiet5_s |=> cmd_out.data == $past(cmd_in.data, 6))
		else $error("bypassed sample altered");
	chk_reset_values: assert property (
		@(posedge clk) disable iff (1'b0)
		rst |-> shaft_filter_on && !robust_filter_on && active_mask == 5'h00)
		else $error("wrong filter enables under reset");
endmodule : notch_filter_bank_control
`default_nettype wire

/* tb/notch_filter_bank_control_bench.sv */
// Self-checking bench of the notch filter bank control block
`timescale 1ns/1ps
`default_nettype none
module notch_filter_bank_control_bench;
	localparam int TUNE  = 2000;
	localparam int WIN   = 400;
	localparam int LIMIT = 30000;
	// Frequency writes at and around both limits
	localparam int EDGE_F[6] = '{0, 9, 10, 4500, 4501, 8191};
	// Design ports
	logic                  clk;
	logic                  rst;
	logic                  ce;
	logic [7:0]            address;
	logic                  read;
	logic                  write;
	logic [31:0]           writedata;
	logic [31:0]           readdata;
	logic                  waitrequest;
	notch_pkg::sample_type cmd_in;
	notch_pkg::sample_type cmd_out;
	notch_pkg::sample_type vib_in;
	logic [1:0]            gain_level;
	notch_pkg::vtd_type    vtd_req;
	logic [4:0]            active_mask;
	logic                  shaft_filter_on;
	logic                  robust_filter_on;
	logic                  excite_on;
	// Bench counters and reference model
	int          err_total;
	int          total_checks;
	int          cycles;
	int          vib_per;
	logic        vib_on;
	int          mode_m;
	int          robust_m;
	int          shaft_m;
	int          freq_m[5];
	int          shape_m[5];
	int          n;
	logic [31:0] rd;
	logic [31:0] v;
	logic [15:0] exp_q[$];

	notch_filter_bank_control #(
		.TUNE_CYCLES(TUNE),
		.WIN_CYCLES (WIN)
	) i_dut (
		.clk             (clk),
		.rst             (rst),
		.ce              (ce),
		.address         (address),
		.read            (read),
		.write           (write),
		.writedata       (writedata),
		.readdata        (readdata),
		.waitrequest     (waitrequest),
		.cmd_in          (cmd_in),
		.cmd_out         (cmd_out),
		.vib_in          (vib_in),
		.gain_level      (gain_level),
		.vtd_req         (vtd_req),
		.active_mask     (active_mask),
		.shaft_filter_on (shaft_filter_on),
		.robust_filter_on(robust_filter_on),
		.excite_on       (excite_on)
	);

	// Clock
	initial clk = 1'b0;
	always #5 clk = ~clk;

	// Cycle count, hang guard and vibration stimulus
	always @(posedge clk) begin
		cycles <= cycles + 1;
		vib_in <= '{vib_on, ((cycles / (vib_per + 1)) % 2) ? 16'sh1000 : -16'sh1000};
		if (cycles == LIMIT) begin
			err_total++;
			print_verdict();
		end
	end

	// Filtered samples must leave in order and unchanged
	always @(posedge clk) begin
		if (cmd_out.valid === 1'b1) begin
			if (exp_q.size() == 0) begin
				check("spurious cmd_out", 32'h0, 32'h1);
			end else begin
				check("cmd_out", {16'h0, exp_q.pop_front()}, {16'h0, cmd_out.data});
			end
		end
	end

	task automatic check(input string name, input logic [31:0] e, input logic [31:0] g);
		total_checks++;
		if (g !== e) begin
			err_total++;
			$display("unexpected %s expected %h seen %h", name, e, g);
		end
	endtask : check

	// Avalon master: hold until waitrequest is sampled low
	task automatic bus(input logic [7:0] a, input logic wr, input logic [31:0] d);
		@(posedge clk);
		address   <= a;
		writedata <= d;
		write     <= wr;
		read      <= !wr;
		// Only the cycle ceiling ends a wait that never answers
		do begin
			@(posedge clk);
		end while (waitrequest !== 1'b0);
		rd    = readdata;
		write <= 1'b0;
		read  <= 1'b0;
	endtask : bus

	function automatic int clampf(input int f);
		return (f < 10) ? 10 : (f > 4500) ? 4500 : f;
	endfunction : clampf

	function automatic logic [31:0] exp_status();
		logic [4:0] m;
		m[0] = (mode_m == 2);
		for (int i = 1; i < 4; i++) m[i] = shape_m[i][4];
		m[4] = shape_m[4][4] && !robust_m[0];
		return {23'h0, robust_m[0], shaft_m[0] && !shape_m[3][4], m, 2'b00};
	endfunction : exp_status

	// Outputs and status against the model
	task automatic check_flags;
		logic [31:0] e;
		e = exp_status();
		bus(notch_pkg::STATUS_OFS, 1'b0, 32'h0);
		check("status", e, rd & 32'h0000_01FF);
		check("active_mask", {27'h0, e[6:2]}, {27'h0, active_mask});
		check("shaft_filter_on", {31'h0, e[7]}, {31'h0, shaft_filter_on});
		check("robust_filter_on", {31'h0, e[8]}, {31'h0, robust_filter_on});
	endtask : check_flags

	// Every register but status read back against the model
	task automatic check_regs;
		bus(notch_pkg::MODE_OFS, 1'b0, 32'h0);
		check("mode", mode_m, rd);
		for (int i = 0; i < 5; i++) begin
			bus(8'(8 * i + 4), 1'b0, 32'h0);
			check("freq", freq_m[i], rd);
			bus(8'(8 * i + 8), 1'b0, 32'h0);
			check("shape", shape_m[i], rd);
		end
		bus(notch_pkg::ROBUST_OFS, 1'b0, 32'h0);
		check("robust", robust_m, rd);
		bus(notch_pkg::SHAFT_OFS, 1'b0, 32'h0);
		check("shaft", shaft_m, rd);
	endtask : check_regs

	// Start adaptive tuning and time it until the excitation stops
	task automatic tune(input int per);
		vib_per = per;
		vib_on  <= 1'b1;
		bus(notch_pkg::MODE_OFS, 1'b1, 32'h1);
		repeat (2) @(negedge clk);
		check("excite_on", 32'h1, {31'h0, excite_on});
		n = 0;
		while (excite_on !== 1'b0 && n < 3 * TUNE) begin
			@(negedge clk);
			n++;
		end
		vib_per = 0;
		vib_on  <= 1'b0;
		mode_m  = 2;
	endtask : tune

	task automatic print_verdict;
		$display("checks %0d mismatches %0d", total_checks, err_total);
		if (err_total == 0 && total_checks > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask : print_verdict

	// Main sequence
	initial begin
		{err_total, total_checks, cycles, vib_per} = '0;
		{address, read, write, writedata, cmd_in, gain_level, vtd_req} = '0;
		ce = 1'b1;
		vib_on = 1'b0;
		rst = 1'b1;
		void'($urandom(98));
		{mode_m, robust_m, shaft_m} = {32'd0, 32'd0, 32'd1};
		foreach (freq_m[i]) {freq_m[i], shape_m[i]} = {32'd4500, 32'd0};
		repeat (20) @(posedge clk);
		rst <= 1'b0;
		check_flags();
		check_regs();
		$display("test reset done");
		// Frequency limits at the boundaries, then random
		for (int k = 0; k < 12; k++) begin
			v = (k < 6) ? EDGE_F[k % 6] : $urandom_range(8191);
			bus(8'(8 * (k % 5) + 4), 1'b1, v);
			freq_m[k % 5] = clampf(int'(v));
		end
		check_regs();
		$display("test freq done");
		// Enable combinations with random shape fields
		for (int k = 0; k < 16; k++) begin
			mode_m   = (k % 3 == 1) ? 2 : (k % 3) * 3 / 2;
			robust_m = k % 2;
			shaft_m  = (k / 2) % 2;
			bus(notch_pkg::MODE_OFS, 1'b1, mode_m);
			bus(notch_pkg::ROBUST_OFS, 1'b1, robust_m);
			bus(notch_pkg::SHAFT_OFS, 1'b1, shaft_m);
			for (int i = 0; i < 5; i++) begin
				v = $urandom;
				if (i > 2) v[4] = k[i - 1];
				bus(8'(8 * i + 8), 1'b1, v);
				shape_m[i] = int'(v & 32'h1F);
			end
			check_flags();
		end
		check_regs();
		$display("test enables done");
		// All sections off: samples pass unchanged after the fixed latency
		{mode_m, robust_m} = '0;
		foreach (shape_m[i]) shape_m[i] = 0;
		bus(notch_pkg::MODE_OFS, 1'b1, 32'h0);
		bus(notch_pkg::ROBUST_OFS, 1'b1, 32'h0);
		for (int i = 0; i < 5; i++) bus(8'(8 * i + 8), 1'b1, 32'h0);
		@(posedge clk);
		v = $urandom;
		cmd_in <= '{1'b1, v[15:0]};
		exp_q.push_back(v[15:0]);
		n = 0;
		do begin
			@(posedge clk);
			n++;
			cmd_in.valid <= 1'b0;
		end while (cmd_out.valid !== 1'b1 && n < 20);
		check("latency", 32'd7, n);
		for (int k = 0; k < 20; k++) begin
			@(posedge clk);
			v = $urandom;
			cmd_in <= '{1'b1, v[15:0]};
			exp_q.push_back(v[15:0]);
		end
		@(posedge clk);
		cmd_in.valid <= 1'b0;
		repeat (10) @(posedge clk);
		check("samples left", 32'h0, exp_q.size());
		$display("test pass through done");
		// Rewrites of the first two frequencies, clamped
		for (int k = 0; k < 2; k++) begin
			v = (k == 1) ? 32'd3 : $urandom_range(8191);
			@(posedge clk);
			vtd_req <= '{1'b1, k[0], v[12:0]};
			@(posedge clk);
			vtd_req.valid <= 1'b0;
			freq_m[k] = clampf(int'(v));
		end
		// A rewrite while the clock enable is low must leave no trace
		ce <= 1'b0;
		@(posedge clk);
		vtd_req <= '{1'b1, 1'b0, 13'd100};
		@(posedge clk);
		vtd_req.valid <= 1'b0;
		ce <= 1'b1;
		check_regs();
		$display("test rewrite done");
		// Tuning with an in-band resonance
		gain_level <= 2'($urandom);
		tune(0);
		check("tune end", 32'h1, {31'h0, n < 2 * WIN + 10});
		shape_m[0] = gain_level;
		bus(notch_pkg::FREQ_OFS, 1'b0, 32'h0);
		check("tuned freq", 32'h1, {31'h0, rd >= 195 && rd <= 201});
		freq_m[0] = int'(rd);
		check_regs();
		check_flags();
		$display("test tune found done");
		// Resonance below the band: nothing found, mode still turns manual
		tune(7);
		check("tune timeout", 32'h1, {31'h0, n >= TUNE - 5 && n <= TUNE + 5});
		check_regs();
		$display("test tune missed done");
		// Abort in mid-observation
		bus(notch_pkg::MODE_OFS, 1'b1, 32'h1);
		bus(notch_pkg::MODE_OFS, 1'b1, 32'h0);
		mode_m = 0;
		// Observation ends one edge after the mode write lands
		repeat (2) @(negedge clk);
		check("excite abort", 32'h0, {31'h0, excite_on});
		check_flags();
		check_regs();
		$display("test abort done");
		// Unmapped address reads zero and ignores writes
		bus(8'h40, 1'b1, 32'hFFFF_FFFF);
		bus(8'h40, 1'b0, 32'h0);
		check("unmapped", 32'h0, rd);
		check_regs();
		$display("test unmapped done");
		print_verdict();
	end
endmodule : notch_filter_bank_control_bench
`default_nettype wire
